// File: include/tx_stats_regs.svh
// offsets, field layout, reset values and counts for the transmit statistics bank
//
// Operation
// - bin one counts lengths 65 to 127
// - bin two counts lengths 128 to 255
// - bin three counts lengths 256 to 511
// - bin four counts lengths 512 to 1023
// - largest bin counts lengths 1024 and above
// - largest bin includes 1522-byte tagged frames
// - length spans destination address through check
// - collision-cut transmissions skip all bins
// - nothing counts while transmitter disabled
// - bins count packets from every source
// - counters are 32 bits, zero after reset
// - multicast counts exclude flow-control frames
// - multicast, broadcast count clear and secure
// - broadcast counter counts broadcast packets
// - context counter bumps on last segment
// - context counter needs transmitter and offload
// - failure counted once per failed context
// - collisions and length errors mean failure
// - no report of failed context progress
`ifndef TX_STATS_REGS_SVH
`define TX_STATS_REGS_SVH

`define TXS_OFF_BIN127    16'h40dc
`define TXS_OFF_BIN255    16'h40e0
`define TXS_OFF_BIN511    16'h40e4
`define TXS_OFF_BIN1023   16'h40e8
`define TXS_OFF_BINMAX    16'h40ec
`define TXS_OFF_MCAST     16'h40f0
`define TXS_OFF_BCAST     16'h40f4
`define TXS_OFF_SEGSENT   16'h40f8
`define TXS_OFF_SEGFAIL   16'h40fc
`define TXS_CNT_MSB       31
`define TXS_CNT_RESET     32'h0000_0000
`define TXS_CNT_MAX       32'hffff_ffff
`define TXS_NUM_CNT       9
`define TXS_LEN_BIN1_LO   11'h041
`define TXS_LEN_BIN2_LO   11'h080
`define TXS_LEN_BIN3_LO   11'h100
`define TXS_LEN_BIN4_LO   11'h200
`define TXS_LEN_BIN5_LO   11'h400
`define TXS_LEN_MAX       11'h5f2

`endif

// File: include/tx_stats_pkg.sv
// types shared by the transmit statistics bank
package tx_stats_pkg;
    typedef enum logic [3:0] {
        CNT_BIN127  = 4'h0,
        CNT_BIN255  = 4'h1,
        CNT_BIN511  = 4'h2,
        CNT_BIN1023 = 4'h3,
        CNT_BINMAX  = 4'h4,
        CNT_MCAST   = 4'h5,
        CNT_BCAST   = 4'h6,
        CNT_SEGSENT = 4'h7,
        CNT_SEGFAIL = 4'h8,
        CNT_NONE    = 4'hf
    } counter_id_t;
    typedef enum logic [0:0] {
        CTX_IDLE   = 1'b0,
        CTX_FAILED = 1'b1
    } ctx_state_t;
endpackage : tx_stats_pkg

// File: design/sat_counter.sv
// one saturating statistics counter that clears on read
`timescale 1ns/1ps
`default_nettype none
`include "tx_stats_regs.svh"
module sat_counter #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    // control
    input  wire logic             incr,
    input  wire logic             clear,
    // value
    output logic [WIDTH-1:0]      count
);
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
        end else if (clear) begin
            // an event in the read cycle is kept rather than lost
            count <= incr ? WIDTH'(1) : '0;
        end else if (incr && count != {WIDTH{1'b1}}) begin
            count <= count + WIDTH'(1);
        end
    end
endmodule : sat_counter
`default_nettype wire

// File: design/tx_statistics_counters.sv
// transmit statistics counter bank with clear-on-read register port
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "tx_stats_regs.svh"
module tx_statistics_counters #(
    parameter int LEN_WIDTH = 11
) (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    // enables
    input  wire logic                 txEnable,
    input  wire logic                 segOffloadEnable,
    // per-packet event from transmit datapath
    input  wire logic                 pktDone,
    input  wire logic [LEN_WIDTH-1:0] pktLength,
    input  wire logic                 pktMulticast,
    input  wire logic                 pktBroadcast,
    input  wire logic                 pktFlowControl,
    input  wire logic                 pktPartial,
    // segmentation context events
    input  wire logic                 segLastLoaded,
    input  wire logic                 segExcessCollision,
    input  wire logic                 segLengthError,
    input  wire logic                 segContextEnd,
    // register port
    input  wire logic [15:0]          regAddr,
    input  wire logic                 regWrite,
    input  wire logic [31:0]          regWriteData,
    input  wire logic                 regRead,
    output logic [31:0]               regReadData
);
    localparam int N = `TXS_NUM_CNT;

    logic [N-1:0]  incr;
    logic [N-1:0]  clear;
    logic [31:0]   count [N];
    tx_stats_pkg::ctx_state_t ctxState;
    tx_stats_pkg::ctx_state_t next_ctxState;
    tx_stats_pkg::counter_id_t readSel;
    logic          segFail;
    logic          pktCounted;

    // length spans destination address through check; supplied so by the datapath
    function automatic tx_stats_pkg::counter_id_t bin_of(input logic [LEN_WIDTH-1:0] len);
        logic [10:0] l;
        l = 11'(len);
        // top bin open-ended so 1522 lands here
        if (l >= `TXS_LEN_BIN5_LO) bin_of = tx_stats_pkg::CNT_BINMAX;
        else if (l >= `TXS_LEN_BIN4_LO) bin_of = tx_stats_pkg::CNT_BIN1023;
        else if (l >= `TXS_LEN_BIN3_LO) bin_of = tx_stats_pkg::CNT_BIN511;
        else if (l >= `TXS_LEN_BIN2_LO) bin_of = tx_stats_pkg::CNT_BIN255;
        else if (l >= `TXS_LEN_BIN1_LO) bin_of = tx_stats_pkg::CNT_BIN127;
        else bin_of = tx_stats_pkg::CNT_NONE;
    endfunction : bin_of

    function automatic tx_stats_pkg::counter_id_t decode(input logic [15:0] a);
        case (a)
            `TXS_OFF_BIN127:  decode = tx_stats_pkg::CNT_BIN127;
            `TXS_OFF_BIN255:  decode = tx_stats_pkg::CNT_BIN255;
            `TXS_OFF_BIN511:  decode = tx_stats_pkg::CNT_BIN511;
            `TXS_OFF_BIN1023: decode = tx_stats_pkg::CNT_BIN1023;
            `TXS_OFF_BINMAX:  decode = tx_stats_pkg::CNT_BINMAX;
            `TXS_OFF_MCAST:   decode = tx_stats_pkg::CNT_MCAST;
            `TXS_OFF_BCAST:   decode = tx_stats_pkg::CNT_BCAST;
            `TXS_OFF_SEGSENT: decode = tx_stats_pkg::CNT_SEGSENT;
            `TXS_OFF_SEGFAIL: decode = tx_stats_pkg::CNT_SEGFAIL;
            default:          decode = tx_stats_pkg::CNT_NONE;
        endcase
    endfunction : decode

    // partial or disabled transmissions never count
    assign pktCounted = pktDone && txEnable && !pktPartial;
    assign segFail = segExcessCollision || segLengthError;

    // one failure per context: latch until the context ends
    always_comb begin
        next_ctxState = ctxState;
        case (ctxState)
            tx_stats_pkg::CTX_IDLE: begin
                if (segFail && !segContextEnd) next_ctxState = tx_stats_pkg::CTX_FAILED;
            end
            tx_stats_pkg::CTX_FAILED: begin
                if (segContextEnd) next_ctxState = tx_stats_pkg::CTX_IDLE;
            end
            default: next_ctxState = tx_stats_pkg::CTX_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) ctxState <= tx_stats_pkg::CTX_IDLE;
        else ctxState <= next_ctxState;
    end

    always_comb begin
        incr = '0;
        // every source counts, no source input is consulted
        for (int i = 0; i < 5; i++) begin
            incr[i] = pktCounted && (bin_of(pktLength) == tx_stats_pkg::counter_id_t'(i));
        end
        // flow control excluded, secure traffic included
        incr[tx_stats_pkg::CNT_MCAST] = pktCounted && pktMulticast && !pktFlowControl;
        incr[tx_stats_pkg::CNT_BCAST] = pktCounted && pktBroadcast;
        incr[tx_stats_pkg::CNT_SEGSENT] = segLastLoaded && txEnable && segOffloadEnable;
        // only a count, no progress figure
        incr[tx_stats_pkg::CNT_SEGFAIL] = segFail && txEnable &&
                                          ctxState == tx_stats_pkg::CTX_IDLE;
    end

    always_comb begin
        clear = '0;
        for (int i = 0; i < N; i++) begin
            clear[i] = regRead && (decode(regAddr) == tx_stats_pkg::counter_id_t'(i));
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_cnt
            sat_counter #(.WIDTH(32)) u_cnt (
                .sys_clk (sys_clk),
                .reset_n (reset_n),
                .incr    (incr[g]),
                .clear   (clear[g]),
                .count   (count[g])
            );
        end
    endgenerate

    assign readSel = decode(regAddr);

    // writes are ignored: all counters read-only; unmapped reads give zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            regReadData <= `TXS_CNT_RESET;
        end else if (regRead && readSel != tx_stats_pkg::CNT_NONE) begin
            regReadData <= count[readSel];
        end else begin
            regReadData <= `TXS_CNT_RESET;
        end
    end

    // write strobe and data have no effect: every counter is read-only
    logic unusedWrite;
    assign unusedWrite = regWrite ^ (|regWriteData);

    // helpers for the checks below
    logic [31:0] selCount;
    logic        anyCountSet;
    // what a read of the current address should hand back
    always_comb begin
        selCount = `TXS_CNT_RESET;
        if (readSel != tx_stats_pkg::CNT_NONE) begin
            selCount = count[readSel];
        end
    end
    always_comb begin
        anyCountSet = 1'b0;
        for (int i = 0; i < N; i++) begin
            anyCountSet = anyCountSet || (count[i] != `TXS_CNT_RESET);
        end
    end

    // qualifying conditions of the multicast, broadcast and context events
    sequence s_bcast_event;
        pktDone && txEnable && !pktPartial && pktBroadcast;
    endsequence
    sequence s_mcast_event;
        pktDone && txEnable && !pktPartial && pktMulticast && !pktFlowControl;
    endsequence
    sequence s_seg_last;
        segLastLoaded && txEnable && segOffloadEnable;
    endsequence
    sequence s_first_fail;
        (segExcessCollision || segLengthError) && txEnable &&
            ctxState == tx_stats_pkg::CTX_IDLE;
    endsequence
    sequence s_fail_pending;
        segFail && txEnable && !segContextEnd;
    endsequence

    // counters and read port zero in reset
    a_reset_zero: assert property (@(posedge sys_clk)
        !reset_n |-> !anyCountSet && regReadData == `TXS_CNT_RESET)
        else $error("counter not zero in reset");

    a_tx_disabled_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !txEnable && !regRead |=> count[0] == $past(count[0]) && count[6] == $past(count[6]))
        else $error("counter moved while transmitter disabled");

    // no increment at all while off
    a_tx_disabled_all: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !txEnable |-> incr == '0)
        else $error("increment while transmitter disabled");

    // shorter packets belong to no bin here
    a_short_none: assert property (@(posedge sys_clk) disable iff (!reset_n)
        pktLength < LEN_WIDTH'(65) |-> incr[4:0] == 5'h00)
        else $error("short packet counted in a bin");

    // 65 to 127 in bin one only
    a_bin1_range: assert property (@(posedge sys_clk) disable iff (!reset_n)
        pktCounted && pktLength >= LEN_WIDTH'(65) && pktLength <= LEN_WIDTH'(127)
        |-> incr[4:0] == 5'h01)
        else $error("65 to 127 not in bin one");

    // 128 to 255 in bin two only
    a_bin2_range: assert property (@(posedge sys_clk) disable iff (!reset_n)
        pktCounted && pktLength >= LEN_WIDTH'(128) && pktLength <= LEN_WIDTH'(255)
        |-> incr[4:0] == 5'h02)
        else $error("128 to 255 not in bin two");

    // 256 to 511 in bin three only
    a_bin3_range: assert property (@(posedge sys_clk) disable iff (!reset_n)
        pktCounted && pktLength >= LEN_WIDTH'(256) && pktLength <= LEN_WIDTH'(511)
        |-> incr[4:0] == 5'h04)
        else $error("256 to 511 not in bin three");

    // 512 to 1023 in bin four only
    a_bin4_range: assert property (@(posedge sys_clk) disable iff (!reset_n)
        pktCounted && pktLength >= LEN_WIDTH'(512) && pktLength <= LEN_WIDTH'(1023)
        |-> incr[4:0] == 5'h08)
        else $error("512 to 1023 not in bin four");

    // 1024 and above in top bin only
    a_bin5_range: assert property (@(posedge sys_clk) disable iff (!reset_n)
        pktCounted && pktLength >= LEN_WIDTH'(1024) |-> incr[4:0] == 5'h10)
        else $error("1024 and above not in top bin");

    // every counted packet of 65 or more in exactly one bin
    a_one_bin: assert property (@(posedge sys_clk) disable iff (!reset_n)
        pktCounted && pktLength >= LEN_WIDTH'(65) |-> $onehot(incr[4:0]))
        else $error("packet not in exactly one bin");

    a_bin1_incr: assert property (@(posedge sys_clk) disable iff (!reset_n)
        pktCounted && pktLength == LEN_WIDTH'(100) && !regRead && count[0] != `TXS_CNT_MAX
        |=> count[0] == $past(count[0]) + 32'h1)
        else $error("bin one missed a packet");

    a_bin_max_frame: assert property (@(posedge sys_clk) disable iff (!reset_n)
        pktCounted && pktLength == LEN_WIDTH'(`TXS_LEN_MAX) |-> incr[4] && !incr[3])
        else $error("max frame not in top bin");

    // 1023 stays below the top bin
    a_bin_boundary: assert property (@(posedge sys_clk) disable iff (!reset_n)
        pktCounted && pktLength == LEN_WIDTH'(1023) |-> incr[3] && !incr[4])
        else $error("1023 binned wrong");

    a_partial_skip: assert property (@(posedge sys_clk) disable iff (!reset_n)
        pktPartial |-> incr[4:0] == 5'h0)
        else $error("partial frame counted");

    a_mcast_flow: assert property (@(posedge sys_clk) disable iff (!reset_n)
        pktFlowControl |-> !incr[5])
        else $error("flow control frame counted as multicast");

    a_mcast_count: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_mcast_event ##0 (!clear[5] && count[5] != `TXS_CNT_MAX)
        |=> count[5] == $past(count[5]) + 32'h1)
        else $error("multicast packet not counted");

    a_bcast_count: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_bcast_event ##0 (!clear[6] && count[6] != `TXS_CNT_MAX)
        |=> count[6] == $past(count[6]) + 32'h1)
        else $error("broadcast packet not counted");

    a_seg_enable: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !segOffloadEnable |-> !incr[7])
        else $error("context counted with offload off");

    a_seg_tx_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !txEnable |-> !incr[7])
        else $error("context counted with transmitter off");

    // last segment loaded bumps the context count
    a_seg_sent: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_seg_last ##0 (!clear[7] && count[7] != `TXS_CNT_MAX)
        |=> count[7] == $past(count[7]) + 32'h1)
        else $error("context not counted");

    // first failure of a context counted
    a_fail_count: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_first_fail ##0 (!clear[8] && count[8] != `TXS_CNT_MAX)
        |=> count[8] == $past(count[8]) + 32'h1)
        else $error("context failure not counted");

    // failure latches until the context ends
    a_fail_latch: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_first_fail ##0 !segContextEnd |=> ctxState == tx_stats_pkg::CTX_FAILED)
        else $error("context failure not latched");

    a_ctx_end: assert property (@(posedge sys_clk) disable iff (!reset_n)
        segContextEnd |=> ctxState == tx_stats_pkg::CTX_IDLE)
        else $error("context end did not reopen counting");

    a_fail_once: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_fail_pending ##1 (!segContextEnd)[*2] |-> !incr[8])
        else $error("second failure counted in one context");

    // read returns the value before the clear
    a_read_data: assert property (@(posedge sys_clk) disable iff (!reset_n)
        regRead |=> regReadData == $past(selCount))
        else $error("read returned wrong value");

    // read data stands one cycle only
    a_idle_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !regRead |=> regReadData == `TXS_CNT_RESET)
        else $error("read data without a read");

    a_unmapped_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
        regRead && readSel == tx_stats_pkg::CNT_NONE |-> clear == '0)
        else $error("unmapped read cleared a counter");

    a_read_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
        regRead && regAddr == `TXS_OFF_BIN127 && !incr[0] |=> count[0] == 32'h0)
        else $error("read did not clear counter");

    // event in the read cycle is kept
    a_read_event: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clear[0] && incr[0] |=> count[0] == 32'h1)
        else $error("event lost in read cycle");

    a_saturate: assert property (@(posedge sys_clk) disable iff (!reset_n)
        count[5] == `TXS_CNT_MAX && !clear[5] |=> count[5] == `TXS_CNT_MAX)
        else $error("counter wrapped");
endmodule : tx_statistics_counters
`default_nettype wire

// File: verif/tx_datapath_model.sv
// transmit datapath stand-in that pulses packet and context events
`timescale 1ns/1ps
`default_nettype none
module tx_datapath_model (
    // clock
    input  wire logic   sys_clk,
    // packet events
    output logic        pktDone,
    output logic [10:0] pktLength,
    output logic        pktMulticast,
    output logic        pktBroadcast,
    output logic        pktFlowControl,
    output logic        pktPartial,
    // context events
    output logic        segLastLoaded,
    output logic        segExcessCollision,
    output logic        segLengthError,
    output logic        segContextEnd
);
    logic [8:0] ev = 9'h000;
    assign {pktDone, pktMulticast, pktBroadcast, pktFlowControl, pktPartial} = ev[8:4];
    assign {segLastLoaded, segExcessCollision, segLengthError, segContextEnd} = ev[3:0];
    initial pktLength = 11'h000;
    // one-cycle event; length is scrambled once it is no longer valid
    task automatic send(input logic [10:0] len, input logic [8:0] f);
        @(posedge sys_clk);
        ev <= f;
        pktLength <= len;
        @(posedge sys_clk);
        ev <= 9'h000;
        pktLength <= ~len;
    endtask : send
endmodule : tx_datapath_model
`default_nettype wire

// File: verif/tx_statistics_counters_tb.sv
// self-checking bench for the transmit statistics bank
`timescale 1ns/1ps
`default_nettype none
module tx_statistics_counters_tb;
    localparam logic [8:0] DONE = 9'h100, MC = 9'h080, BC = 9'h040, FC = 9'h020;
    localparam logic [8:0] PART = 9'h010, LAST = 9'h008, EXC = 9'h004;
    localparam logic [8:0] LERR = 9'h002, CEND = 9'h001;
    logic sys_clk, reset_n, txEnable, segOffloadEnable, regWrite, regRead;
    logic pktDone, pktMulticast, pktBroadcast, pktFlowControl, pktPartial;
    logic segLastLoaded, segExcessCollision, segLengthError, segContextEnd;
    logic [10:0] pktLength;
    logic [15:0] regAddr;
    logic [31:0] regWriteData, regReadData;
    int nMismatch = 0, checkCount = 0, cycles = 0;
    logic [10:0] lens [11] = '{11'h040, 11'h041, 11'h07f, 11'h080, 11'h0ff, 11'h100,
                               11'h1ff, 11'h200, 11'h3ff, 11'h400, 11'h5f2};
    logic [31:0] expA [7] = '{32'h4, 32'h2, 32'h2, 32'h2, 32'h2, 32'h1, 32'h1};
    tx_statistics_counters dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
        .txEnable(txEnable), .segOffloadEnable(segOffloadEnable), .pktDone(pktDone),
        .pktLength(pktLength), .pktMulticast(pktMulticast), .pktBroadcast(pktBroadcast),
        .pktFlowControl(pktFlowControl), .pktPartial(pktPartial),
        .segLastLoaded(segLastLoaded), .segExcessCollision(segExcessCollision),
        .segLengthError(segLengthError), .segContextEnd(segContextEnd),
        .regAddr(regAddr), .regWrite(regWrite), .regWriteData(regWriteData),
        .regRead(regRead), .regReadData(regReadData));
    tx_datapath_model partner_u (.sys_clk(sys_clk), .pktDone(pktDone),
        .pktLength(pktLength), .pktMulticast(pktMulticast), .pktBroadcast(pktBroadcast),
        .pktFlowControl(pktFlowControl), .pktPartial(pktPartial),
        .segLastLoaded(segLastLoaded), .segExcessCollision(segExcessCollision),
        .segLengthError(segLengthError), .segContextEnd(segContextEnd));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checkCount, nMismatch);
        if (nMismatch == 0 && checkCount > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nMismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // data is looked at mid-cycle, the only cycle it stands
    task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        @(negedge sys_clk);
        chk(regReadData, exp);
    endtask : rdchk
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask : wr
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            nMismatch++;
            give_verdict();
        end
    end
    initial begin
        {regWrite, regRead, regAddr, regWriteData} = '0;
        txEnable = 1'b1;
        segOffloadEnable = 1'b1;
        reset_n = 1'b0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 9; i++) rdchk(16'(i * 4) + 16'h40dc, 32'h0);
        foreach (lens[i]) partner_u.send(lens[i], DONE);
        partner_u.send(11'h064, DONE | PART);
        partner_u.send(11'h040, DONE | MC | FC);
        partner_u.send(11'h064, DONE | MC);
        partner_u.send(11'h064, DONE | BC);
        for (int i = 0; i < 7; i++) begin
            rdchk(16'(i * 4) + 16'h40dc, expA[i]);
            rdchk(16'(i * 4) + 16'h40dc, 32'h0);
        end
        @(posedge sys_clk) txEnable <= 1'b0;
        partner_u.send(11'h064, DONE | MC | BC);
        partner_u.send(11'h000, LAST | EXC | CEND);
        rdchk(16'h40dc, 32'h0);
        rdchk(16'h40f0, 32'h0);
        rdchk(16'h40f8, 32'h0);
        rdchk(16'h40fc, 32'h0);
        @(posedge sys_clk) txEnable <= 1'b1;
        segOffloadEnable <= 1'b0;
        partner_u.send(11'h000, LAST);
        rdchk(16'h40f8, 32'h0);
        @(posedge sys_clk) segOffloadEnable <= 1'b1;
        partner_u.send(11'h000, LAST | CEND);
        rdchk(16'h40f8, 32'h1);
        partner_u.send(11'h000, EXC);
        partner_u.send(11'h000, LERR);
        partner_u.send(11'h000, CEND);
        partner_u.send(11'h000, LERR | CEND);
        rdchk(16'h40fc, 32'h2);
        partner_u.send(11'h064, DONE);
        wr(16'h40dc, 32'hffff_ffff);
        rdchk(16'h4100, 32'h0);
        rdchk(16'h40dc, 32'h1);
        // an event in the read cycle survives the clear
        fork
            partner_u.send(11'h064, DONE);
            rdchk(16'h40dc, 32'h0);
        join
        rdchk(16'h40dc, 32'h1);
        partner_u.send(11'h064, DONE | BC);
        @(posedge sys_clk) reset_n <= 1'b0;
        @(posedge sys_clk) reset_n <= 1'b1;
        rdchk(16'h40f4, 32'h0);
        give_verdict();
    end
endmodule : tx_statistics_counters_tb
`default_nettype wire
